// ===== chl_card_model.sv
// Card model on the far side of the three-wire link.
// Assumes the resolved data wire as sdl, a four-state flag quad and
// the host's receive edge choice as late.
`timescale 1ns/1ps
module chl_card_model (
   input wire logic bus_state_line,
   input wire logic serial_clock_out,
   input wire logic sdl,
   input wire logic quad,
   input wire logic late,
   input wire logic [7:0] hs_wait,
   output logic card_o,
   output logic card_oe
);
   int ph = 0;
   int n = 0;
   logic [7:0] tpc = 8'h00;
   logic [7:0] rb;
   logic sck_d = 1'b0;
   logic bitv;
   // Command byte arrives MSB first in state one
   always @(posedge serial_clock_out)
   begin
      if (ph == 0 && bus_state_line)
      begin
         ph = 1;
         n = 0;
      end
      if (ph == 1 && n < 8)
      begin
         tpc = {tpc[6:0], sdl};
         n++;
      end
   end
   // Bit boundaries; a stalled clock simply holds our data
   always @(negedge serial_clock_out)
   begin
      #1;
      if (ph == 1 && n == 8 && quad)
      begin
         ph = bus_state_line ? 3 : 2;
         n = 0;
      end
      else if (ph == 2 && bus_state_line)
      begin
         ph = 3;
         n = 0;
      end
      else if (ph > 1)
         n++;
   end
   // two-state frames end without state three
   always @(negedge bus_state_line)
      if (ph == 3 || !quad)
         ph = 0;
   // card answers only inside a packet
   assign card_oe = (ph == 2 && tpc[7]) || ph == 3;
   assign rb = 8'hA0 + 8'(n / 8);
   assign bitv = ph == 3 ? n >= int'(hs_wait) : rb[7 - n % 8];
   // Clock level just after each edge of the serial clock
   always @(serial_clock_out)
      sck_d <= #1 serial_clock_out;
   // true bit only in the half around the chosen edge; the
   // other half shows the inverse, so a wrong-edge sample reads junk
   assign card_o = bitv ^ (late ? !sck_d : sck_d);
endmodule : chl_card_model

// ===== chl_fifo.sv
// Byte FIFO with valid and ready on both sides.
// Assumes a synchronous, already released active-low reset.
`timescale 1ns/1ps
module chl_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW:0] wr;
      logic [AW:0] rd;
   } chl_fifo_s;

   chl_fifo_s q;
   chl_fifo_s d;
   logic full;
   logic empty;

   // Extra pointer bit tells full from empty
   assign empty = (q.wr == q.rd);
   assign full = (q.wr[AW-1:0] == q.rd[AW-1:0]) && (q.wr[AW] != q.rd[AW]);
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = q.mem[q.rd[AW-1:0]];

   // Push and pop may happen in the same cycle
   always_comb
   begin
      d = q;
      if (in_valid && !full)
      begin
         d.mem[q.wr[AW-1:0]] = in_data;
         d.wr = q.wr + 1'b1;
      end
      if (out_ready && !empty)
      begin
         d.rd = q.rd + 1'b1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

endmodule : chl_fifo

// ===== chl_host.sv
// Host end of a three-wire card link: bus-state line, serial data line
// and serial clock. Packet sequencing, bit engine and receive buffer.
// Assumes commands and transmit bytes come from logic on mclk; the data
// pin is resolved outside from the output enable.
`timescale 1ns/1ps

module chl_host (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic receive_edge_select,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic cmd_write,
   input wire logic [7:0] cmd_tpc,
   input wire logic [7:0] cmd_len,
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   output logic [7:0] rx_data,
   output logic rx_valid,
   input wire logic rx_ready,
   input wire logic mode_restore,
   output logic two_state_mode,
   output logic busy,
   output logic done,
   output logic error,
   output logic bus_state_line,
   output logic serial_clock_out,
   input wire logic serial_data_line_i,
   output logic serial_data_line_o,
   output logic serial_data_line_oe
);

   typedef struct packed {
      chl_pkg::chl_phase_e phase;
      logic two_st;
      logic write;
      logic load;
      logic [2:0] div;
      logic [2:0] bitc;
      logic [7:0] bytec;
      logic [7:0] len;
      logic [7:0] shreg;
      logic [7:0] tmo;
      logic rdy;
      logic sync1;
      logic sync2;
      logic sclk;
      logic bs;
      logic sdo;
      logic sdoe;
      logic done;
      logic err;
   } chl_state_s;

   chl_state_s q;
   chl_state_s d;
   logic [1:0] rst_sync_q;
   logic rst_n;
   logic fifo_in_ready;
   logic push;
   logic [7:0] push_data;
   logic stall;
   logic run;
   logic bit_end;
   logic sample;
   logic pkt_end;
   logic card_ready;
   logic [7:0] smp_byte;

   // Reset released through two flops; assertion stays asynchronous
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rst_sync_q <= 2'h0;
      end
      else
      begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // Received bytes wait here; a full buffer halts the serial clock
   chl_fifo #(
      .WIDTH(chl_pkg::BYTE_W),
      .DEPTH(chl_pkg::RX_FIFO_DEPTH)
   ) u_rx_fifo (
      .clk(mclk),
      .rst_n(rst_n),
      .in_valid(push),
      .in_ready(fifo_in_ready),
      .in_data(push_data),
      .out_valid(rx_valid),
      .out_ready(rx_ready),
      .out_data(rx_data)
   );

   assign cmd_ready = (q.phase == chl_pkg::PH_STATE0);
   assign busy = (q.phase != chl_pkg::PH_STATE0);
   assign two_state_mode = q.two_st;
   assign done = q.done;
   assign error = q.err;
   assign bus_state_line = q.bs;
   assign serial_clock_out = q.sclk;
   assign serial_data_line_o = q.sdo;
   assign serial_data_line_oe = q.sdoe;

   // Clock halts low at a byte start when data or room is missing
   assign stall = (q.phase == chl_pkg::PH_STATE2) && q.load &&
                  (q.write ? !tx_valid : !fifo_in_ready);
   assign run = (q.phase != chl_pkg::PH_STATE0) && !stall;
   assign bit_end = run && (q.div == chl_pkg::DIV_LAST);
   assign sample = run && (q.div == (receive_edge_select ?
                   chl_pkg::DIV_LAST : chl_pkg::SAMPLE_RISE));
   assign smp_byte = {q.shreg[6:0], q.sync2};
   // Late sample coincides with bit end, so use the live value
   assign card_ready = receive_edge_select ? q.sync2 : q.rdy;

   // Sequencer, bit engine and divider in one next-state process
   always_comb
   begin
      d = q;
      d.done = 1'b0;
      d.err = 1'b0;
      tx_ready = 1'b0;
      push = 1'b0;
      push_data = q.shreg;
      pkt_end = 1'b0;
      // Data pin input passes two flops before use
      d.sync1 = serial_data_line_i;
      d.sync2 = q.sync1;

      // Input sampling for read data and card ready
      if (sample && (q.phase == chl_pkg::PH_STATE2) && !q.write)
      begin
         d.shreg = smp_byte;
      end
      if (sample && (q.phase == chl_pkg::PH_STATE3))
      begin
         d.rdy = q.sync2;
      end

      unique case (q.phase)
         chl_pkg::PH_STATE0:
         begin
            d.bs = chl_pkg::BS_LOW;
            d.sdoe = 1'b0;
            d.sdo = chl_pkg::SDO_RST;
            if (mode_restore)
            begin
               d.two_st = 1'b0;
            end
            if (cmd_valid)
            begin
               d.phase = chl_pkg::PH_STATE1;
               d.bs = chl_pkg::BS_HIGH;
               d.shreg = cmd_tpc;
               d.sdo = cmd_tpc[7];
               d.sdoe = 1'b1;
               d.write = cmd_write;
               d.len = cmd_len;
               d.bitc = 3'h0;
               d.bytec = 8'h00;
               d.tmo = 8'h00;
            end
         end
         chl_pkg::PH_STATE1:
         begin
            // Command byte, most significant bit first
            if (bit_end)
            begin
               if (q.bitc == chl_pkg::BIT_LAST)
               begin
                  d.bitc = 3'h0;
                  if (q.len == 8'h00)
                  begin
                     pkt_end = 1'b1;
                  end
                  else
                  begin
                     d.phase = chl_pkg::PH_STATE2;
                     d.bs = q.two_st ? chl_pkg::BS_HIGH : chl_pkg::BS_LOW;
                     d.sdoe = q.write;
                     d.load = 1'b1;
                  end
               end
               else
               begin
                  d.bitc = q.bitc + 3'h1;
                  d.shreg = {q.shreg[6:0], 1'b0};
                  d.sdo = q.shreg[6];
               end
            end
         end
         chl_pkg::PH_STATE2:
         begin
            // Byte start: take a transmit byte or claim buffer room
            if (q.load && !stall)
            begin
               d.load = 1'b0;
               if (q.write)
               begin
                  tx_ready = 1'b1;
                  d.shreg = tx_data;
                  d.sdo = tx_data[7];
               end
            end
            if (bit_end)
            begin
               if (q.bitc == chl_pkg::BIT_LAST)
               begin
                  d.bitc = 3'h0;
                  if (!q.write)
                  begin
                     push = 1'b1;
                     push_data = receive_edge_select ? smp_byte : q.shreg;
                  end
                  if (q.bytec == q.len - 8'h01)
                  begin
                     pkt_end = 1'b1;
                  end
                  else
                  begin
                     d.bytec = q.bytec + 8'h01;
                     d.load = 1'b1;
                  end
               end
               else
               begin
                  d.bitc = q.bitc + 3'h1;
                  if (q.write)
                  begin
                     d.shreg = {q.shreg[6:0], 1'b0};
                     d.sdo = q.shreg[6];
                  end
               end
            end
         end
         chl_pkg::PH_STATE3:
         begin
            // Handshake: card pulls data high when ready
            if (bit_end)
            begin
               if (card_ready)
               begin
                  d.phase = chl_pkg::PH_STATE0;
                  d.bs = chl_pkg::BS_LOW;
                  d.done = 1'b1;
               end
               else if (q.tmo == chl_pkg::HSK_TMO_LAST)
               begin
                  d.phase = chl_pkg::PH_STATE0;
                  d.bs = chl_pkg::BS_LOW;
                  d.two_st = 1'b1;
                  d.err = 1'b1;
               end
               else
               begin
                  d.tmo = q.tmo + 8'h01;
               end
            end
         end
      endcase

      if (pkt_end)
      begin
         d.sdoe = 1'b0;
         d.sdo = chl_pkg::SDO_RST;
         if (q.two_st)
         begin
            d.phase = chl_pkg::PH_STATE0;
            d.bs = chl_pkg::BS_LOW;
            d.done = 1'b1;
         end
         else
         begin
            d.phase = chl_pkg::PH_STATE3;
            d.bs = chl_pkg::BS_HIGH;
            d.tmo = 8'h00;
            d.rdy = 1'b0;
         end
      end

      // clock low half first; state and data move at its fall
      if (run)
      begin
         d.div = (q.div == chl_pkg::DIV_LAST) ? chl_pkg::DIV_RST :
                 q.div + 3'h1;
      end
      else if (q.phase == chl_pkg::PH_STATE0)
      begin
         d.div = chl_pkg::DIV_RST;
      end
      d.sclk = (d.div >= chl_pkg::SAMPLE_RISE);
   end

   // Whole controller state registered at once
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q <= '0;
         q.phase <= chl_pkg::PH_STATE0;
         q.sclk <= chl_pkg::SCLK_RST;
         q.bs <= chl_pkg::BS_LOW;
         q.sdo <= chl_pkg::SDO_RST;
         q.div <= chl_pkg::DIV_RST;
      end
      else
      begin
         q <= d;
      end
   end

endmodule : chl_host

// ===== chl_host_sva.sv
// Checker on the card link host ports, all in the mclk domain.
// Assumes it is bound into chl_host and sees only its ports.
`timescale 1ns/1ps
module chl_host_sva (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic cmd_valid,
   input wire logic cmd_ready,
   input wire logic busy,
   input wire logic done,
   input wire logic error,
   input wire logic two_state_mode,
   input wire logic bus_state_line,
   input wire logic serial_clock_out,
   input wire logic serial_data_line_o,
   input wire logic serial_data_line_oe
);
   default clocking @(posedge mclk);
   endclocking
   default disable iff (!arst_n);
   // Frame opens in state one with the host driving data
   sequence frame_s;
      busy && bus_state_line && serial_data_line_oe && !serial_clock_out;
   endsequence
   // High half of a bit lasts four cycles
   sequence high_s;
      serial_clock_out [*3] ##1 !serial_clock_out;
   endsequence
   idle_quiet_a: assert property (
      cmd_ready |-> !bus_state_line && !serial_data_line_oe)
      else $error("state zero not quiet");
   frame_start_a: assert property (
      cmd_valid && cmd_ready |=> frame_s) else $error("bad frame start");
   host_starts_a: assert property (
      cmd_ready && !cmd_valid |=> !busy) else $error("frame without request");
   clock_still_a: assert property (
      !busy |-> !serial_clock_out) else $error("clock runs while idle");
   clock_high_a: assert property (
      $rose(serial_clock_out) |=> high_s) else $error("clock high not 4");
   state_edge_a: assert property (
      $changed(bus_state_line) |-> !serial_clock_out)
      else $error("state moved mid bit");
   data_edge_a: assert property (
      serial_data_line_oe && $changed(serial_data_line_o)
      |-> !serial_clock_out)
      else $error("data moved mid bit");
   error_mode_a: assert property (
      error |-> ##[0:1] two_state_mode) else $error("no two-state fallback");
   pulse_once_a: assert property (
      done |=> !done && !error) else $error("done not single");
   two_end_a: assert property (
      two_state_mode && $fell(bus_state_line) |-> cmd_ready)
      else $error("two-state frame went on");
endmodule : chl_host_sva
bind chl_host chl_host_sva u_sva (.mclk, .arst_n, .cmd_valid, .cmd_ready,
   .busy, .done, .error, .two_state_mode, .bus_state_line,
   .serial_clock_out, .serial_data_line_o, .serial_data_line_oe);

// ===== chl_pkg.sv
// Shared constants and types for the card link host controller.
// Assumes a 20 MHz system clock; all link timing derives from it.
package chl_pkg;

   // System clock and serial clock periods, in nanoseconds
   localparam int MCLK_PERIOD_NS = 50;
   localparam int SCLK_PERIOD_NS = 400;

   // Serial bit time in system clocks, and the rising-edge position
   localparam int SCLK_DIV = SCLK_PERIOD_NS / MCLK_PERIOD_NS;
   localparam logic [2:0] DIV_LAST = 3'(SCLK_DIV - 1);
   localparam logic [2:0] SAMPLE_RISE = 3'(SCLK_DIV / 2);
   localparam logic [2:0] DIV_RST = 3'h0;

   // Bits per byte and last bit index of a byte
   localparam int BYTE_W = 8;
   localparam logic [2:0] BIT_LAST = 3'h7;

   // Bit times to wait for card ready in the handshake state
   localparam logic [7:0] HSK_TMO_LAST = 8'h3F;

   // Receive FIFO depth in bytes
   localparam int RX_FIFO_DEPTH = 16;

   // Levels of the bus-state line; one and three high, zero low, two low in four-state mode and high in two-state mode
   localparam logic BS_LOW = 1'b0;
   localparam logic BS_HIGH = 1'b1;

   // Values held while idle and after reset
   localparam logic SCLK_RST = 1'b0;
   localparam logic SDO_RST = 1'b1;

   // Packet sequencer phases; each names the bus state it occupies
   typedef enum logic [1:0] {
      PH_STATE0,
      PH_STATE1,
      PH_STATE2,
      PH_STATE3
   } chl_phase_e;

endpackage : chl_pkg

// ===== tb_top.sv
// Self-checking bench for the card link host with a card model.
// Assumes chl_pkg, the FIFO, host, model and checker compiled before.
`timescale 1ns/1ps
module tb_top;
   logic mclk = 1'b0, arst_n = 1'b0, sel = 1'b0, cmd_valid = 1'b0;
   logic cmd_write = 1'b0, rx_ready = 1'b1, mode_restore = 1'b0;
   logic [7:0] cmd_tpc = 8'h00, cmd_len = 8'h00, hs_wait = 8'h00;
   logic cmd_ready, tx_ready, rx_valid, two_state_mode, busy, done, error;
   logic bs, sclk, sd_o, sd_oe, cd_o, cd_oe, tx_valid, sdl, ok;
   logic [7:0] tx_data, rx_data;
   logic [7:0] txb [4];
   int ti = 0, tn = 0, errors = 0, compares = 0, cyc = 0, cdrv = 0;
   logic bsq [$];
   logic sdq [$];
   logic [7:0] rxq [$];
   always #25 mclk = ~mclk;
   // Undriven wire shows the inverse of the host's own level
   assign sdl = sd_oe ? sd_o : cd_oe ? cd_o : !sd_o;
   assign tx_valid = ti < tn;
   assign tx_data = txb[ti % 4];
   chl_host uut (.mclk, .arst_n, .receive_edge_select(sel), .cmd_valid,
      .cmd_ready, .cmd_write, .cmd_tpc, .cmd_len, .tx_data, .tx_valid,
      .tx_ready, .rx_data, .rx_valid, .rx_ready, .mode_restore,
      .two_state_mode, .busy, .done, .error, .bus_state_line(bs),
      .serial_clock_out(sclk), .serial_data_line_i(sdl),
      .serial_data_line_o(sd_o), .serial_data_line_oe(sd_oe));
   chl_card_model card (.bus_state_line(bs), .serial_clock_out(sclk),
      .sdl, .quad(!two_state_mode), .late(sel), .hs_wait, .card_o(cd_o),
      .card_oe(cd_oe));
   // Link log at each clock rise
   always @(posedge sclk)
   begin
      bsq.push_back(bs);
      sdq.push_back(sdl);
   end
   // Streams, card drive count and the hang limit
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      if (tx_valid && tx_ready)
         ti <= ti + 1;
      if (rx_valid && rx_ready)
         rxq.push_back(rx_data);
      if (cd_oe)
         cdrv <= cdrv + 1;
      if (cyc == 20000)
      begin
         errors++;
         give_verdict();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp)
      begin
         errors++;
         $display("MISMATCH %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic give_verdict();
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : give_verdict
   // Request one packet; the log restarts with it
   task automatic start(input logic wr, input logic [7:0] tpc, len);
      bsq.delete();
      sdq.delete();
      rxq.delete();
      cmd_write <= wr;
      cmd_tpc <= tpc;
      cmd_len <= len;
      cmd_valid <= 1'b1;
      @(posedge mclk);
      cmd_valid <= 1'b0;
   endtask : start
   task automatic fin();
      while (!(done || error))
         @(posedge mclk);
      ok = done;
      @(posedge mclk);
   endtask : fin
   // Compare logged state and data bits, first bit first
   task automatic link(input int nb, input logic [31:0] bsx, sdx);
      chk(8'(bsq.size()), 8'(nb));
      for (int i = 0; i < nb; i++)
      begin
         chk(bsq[i], bsx[nb-1-i]);
         chk(sdq[i], sdx[nb-1-i]);
      end
   endtask : link
   task automatic sc_write();
      txb[0] = 8'h5C;
      txb[1] = 8'hC3;
      ti <= 0;
      tn <= 2;
      hs_wait <= 8'h03;
      start(1'b1, 8'h2A, 8'h02);
      fin();
      chk(ok, 1'b1);
      chk(8'(ti), 8'h02);
      link(28, 32'h0FF0000F, 32'h02A5CC31);
   endtask : sc_write
   // Read, with optional FIFO stall: card waits while the host refuses
   task automatic sc_read(input logic s, input logic [7:0] len,
      input logic st);
      sel <= s;
      tn <= 0;
      rx_ready <= !st;
      start(1'b0, 8'h8B, len);
      if (st)
      begin
         repeat (1400) @(posedge mclk);
         chk(busy, 1'b1);
         chk(8'(rxq.size()), 8'h00);
         rx_ready <= 1'b1;
      end
      fin();
      chk(8'(rxq.size()), len);
      for (int i = 0; i < int'(len); i++)
         chk(rxq[i], 8'hA0 + 8'(i));
      chk(rx_valid, 1'b0);
   endtask : sc_read
   task automatic sc_error();
      hs_wait <= 8'hFF;
      tn <= 0;
      start(1'b1, 8'h11, 8'h00);
      fin();
      chk(ok, 1'b0);
      chk(two_state_mode, 1'b1);
      txb[0] = 8'h96;
      ti <= 0;
      tn <= 1;
      cdrv <= 0;
      start(1'b1, 8'h33, 8'h01);
      fin();
      chk(ok, 1'b1);
      chk(8'(cdrv), 8'h00);
      chk(8'(ti), 8'h01);
      link(16, 32'h0000FFFF, 32'h00003396);
      mode_restore <= 1'b1;
      repeat (2) @(posedge mclk);
      mode_restore <= 1'b0;
      @(posedge mclk);
      chk(two_state_mode, 1'b0);
   endtask : sc_error
   // Reset, then the scenarios in turn
   initial
   begin
      repeat (4) @(posedge mclk);
      arst_n <= 1'b1;
      repeat (3) @(posedge mclk);
      sc_write();
      sc_read(1'b0, 8'h03, 1'b0);
      sc_read(1'b1, 8'h12, 1'b1);
      sc_error();
      give_verdict();
   end
endmodule : tb_top
